// *** hdl/tpw_pkg.sv ***
// Types shared by the timer PWM block
package tpw_pkg;

    // Timer clock source, coded as the two-bit select field
    typedef enum logic [1:0] {
        TPW_CLK_DIV4 = 2'b00,
        TPW_CLK_DIV2 = 2'b01,
        TPW_CLK_DIV8 = 2'b10,
        TPW_CLK_EXT = 2'b11
    } tpw_clk_sel_e;

    // A 16-bit value kept as two separate byte registers
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } tpw_pair_s;

    // Control bits from the two control registers
    typedef struct packed {
        logic irq_en;
        logic out_en;
        logic pwm;
        logic one_pulse_mode;
        logic lvl2;
        logic lvl1;
        tpw_clk_sel_e sel;
    } tpw_ctrl_s;

endpackage : tpw_pkg

// *** hdl/tpw_regs.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus (one aligned word each)
// ----------------------------------------------------------------
`define TPW_OFS_CTRL_ONE 8'h00
`define TPW_OFS_CTRL_TWO 8'h04
`define TPW_OFS_STATUS 8'h08
`define TPW_OFS_CNT_HI 8'h0C
`define TPW_OFS_CNT_LO 8'h10
`define TPW_OFS_CMP1_HI 8'h14
`define TPW_OFS_CMP1_LO 8'h18
`define TPW_OFS_CMP2_HI 8'h1C
`define TPW_OFS_CMP2_LO 8'h20
`define TPW_OFS_CAP1_HI 8'h24
`define TPW_OFS_CAP1_LO 8'h28
`define TPW_OFS_CAP2_HI 8'h2C
`define TPW_OFS_CAP2_LO 8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
// timer_control_one
`define TPW_C1_LVL1 0
`define TPW_C1_LVL2 1
`define TPW_C1_IRQ_EN 7
// timer_control_two
`define TPW_C2_SEL_LO 2
`define TPW_C2_SEL_HI 3
`define TPW_C2_PWM 4
`define TPW_C2_OPM 5
`define TPW_C2_OUT_EN 7
// status (write one to clear)
`define TPW_ST_CAP2 4
`define TPW_ST_CMP2 5
`define TPW_ST_CMP1 6
`define TPW_ST_CAP1 7

// ----------------------------------------------------------------
// Reset and reload values
// ----------------------------------------------------------------
`define TPW_CNT_RELOAD 16'hFFFC
`define TPW_CNT_RESET 16'hFFFC
`define TPW_CMP_RESET 8'hFF
`define TPW_BYTE_ZERO 8'h00
`define TPW_WORD_ZERO 32'h0000_0000
`define TPW_CNT_ONE 16'h0001

// ----------------------------------------------------------------
// Prescale terminal counts (factor minus one)
// ----------------------------------------------------------------
`define TPW_PRE_DIV2 3'h1
`define TPW_PRE_DIV4 3'h3
`define TPW_PRE_DIV8 3'h7
`define TPW_PRE_ZERO 3'h0

`endif

// *** hdl/tpw_timer.sv ***
// Timer with pulse width modulation mode and a classic Wishbone slave
//
// Chosen here: the Wishbone slave port and the register addresses.
`include "tpw_regs.svh"

// Functional notes
// - Period comes from second compare, pulse edge from first compare.
// - PWM mode owns compare one and compare two registers.
// - Compare values double buffered; loaded at second compare match.
// - First compare match drives pin to first match level.
// - Second compare match drives pin to second match level.
// - Output enable routes pin to compare output, not port data.
// - Counter clocked by CPU clock divided by 2, 4 or 8.
// - External clock: one count per period; time is value plus five.
// - Level one high, level two low gives pulse of compare difference.
// - Equal levels hold the pin constant.
// - Second compare match reloads counter with FFFC.
// - High byte write inhibits compare until low byte written.
// - Compare flags never set in PWM mode.
// - Second compare match sets capture one flag; may interrupt.
// - Capture one input disconnected in PWM; capture two still works.
// - PWM and one-pulse both set: only PWM acts.
// - Read-only low byte of the capture one value.
// - Compare values held as byte pairs, compared bytewise.
module tpw_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_clk_i,
    input wire logic capture_one_input_i,
    input wire logic capture_two_input_i,
    input wire logic cpu_irq_mask_i,
    input wire logic port_data_i,
    output logic pwm_output_pin_o,
    output logic pin_select_o,
    output logic timer_irq_o
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Prescaler terminal count for a clock source
    function automatic logic [2:0] pre_last(
        input tpw_pkg::tpw_clk_sel_e sel
    );
        logic [2:0] r;
        r = `TPW_PRE_DIV4;
        case (sel)
            tpw_pkg::TPW_CLK_DIV2: r = `TPW_PRE_DIV2;
            tpw_pkg::TPW_CLK_DIV8: r = `TPW_PRE_DIV8;
            default: r = `TPW_PRE_DIV4;
        endcase
        return r;
    endfunction : pre_last

    // Byte-wise match of the counter against a compare pair
    function automatic logic pair_match(
        input logic [15:0] cnt,
        input tpw_pkg::tpw_pair_s cmp
    );
        return (cnt[15:8] == cmp.hi) && (cnt[7:0] == cmp.lo);
    endfunction : pair_match

    // Zero-extend a register byte onto the bus
    function automatic logic [31:0] to_word(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction : to_word

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tpw_pkg::tpw_ctrl_s ctrl_q;
    tpw_pkg::tpw_pair_s cmp1_sh_q;
    tpw_pkg::tpw_pair_s cmp2_sh_q;
    tpw_pkg::tpw_pair_s cmp1_act_q;
    tpw_pkg::tpw_pair_s cmp2_act_q;
    tpw_pkg::tpw_pair_s cap1_q;
    tpw_pkg::tpw_pair_s cap2_q;
    logic inh1_q;
    logic inh2_q;
    logic [15:0] cnt_q;
    logic [2:0] pre_q;
    logic ext_prev_q;
    logic cap1_prev_q;
    logic cap2_prev_q;
    logic out_q;
    logic flag_cap1_q;
    logic flag_cap2_q;
    logic flag_cmp1_q;
    logic flag_cmp2_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic rd;
    logic wr_lane;
    logic pwm_mode;
    logic tick;
    logic hit1;
    logic hit2;
    logic cap1_edge;
    logic cap2_edge;

    // A request is taken once; ack_q blocks the repeat cycle
    assign req = wb_cyc_i && wb_stb_i && !ack_q && ce_i;
    assign wr_lane = req && wb_we_i && wb_sel_i[0];
    assign wr = wr_lane;
    assign rd = req && !wb_we_i;

    // One-pulse mode is ignored whenever PWM is set
    assign pwm_mode = ctrl_q.pwm;

    // ------------------------------------------------------------
    // Timer clock tick
    // ------------------------------------------------------------

    // Internal source: prescaler wraps at its terminal count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= `TPW_PRE_ZERO;
        end else if (ce_i) begin
            if (pre_q >= pre_last(ctrl_q.sel)) begin
                pre_q <= `TPW_PRE_ZERO;
            end else begin
                pre_q <= pre_q + 3'h1;
            end
        end
    end

    // Edge history for the external clock and capture pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_prev_q <= 1'b0;
            cap1_prev_q <= 1'b0;
            cap2_prev_q <= 1'b0;
        end else if (ce_i) begin
            ext_prev_q <= ext_clk_i;
            cap1_prev_q <= capture_one_input_i;
            cap2_prev_q <= capture_two_input_i;
        end
    end

    // External source counts one step per rising edge
    always_comb begin
        if (ctrl_q.sel == tpw_pkg::TPW_CLK_EXT) begin
            tick = ce_i && ext_clk_i && !ext_prev_q;
        end else begin
            tick = ce_i && (pre_q >= pre_last(ctrl_q.sel));
        end
    end

    // ------------------------------------------------------------
    // Compare matches
    // ------------------------------------------------------------

    // A match is seen on the tick that leaves the matching count;
    // an inhibited channel, halfway through a two-byte write, is
    // kept quiet so a torn value cannot fire until the low byte is written
    assign hit1 = tick && !inh1_q && pair_match(cnt_q, cmp1_act_q);
    assign hit2 = tick && !inh2_q && pair_match(cnt_q, cmp2_act_q);

    // Capture edges; capture one is cut off in PWM mode
    assign cap1_edge = ce_i && !pwm_mode &&
                       capture_one_input_i && !cap1_prev_q;
    assign cap2_edge = ce_i && capture_two_input_i && !cap2_prev_q;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------

    // Period end reloads; otherwise count and wrap naturally
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= `TPW_CNT_RESET;
        end else if (pwm_mode && hit2) begin
            cnt_q <= `TPW_CNT_RELOAD;
        end else if (tick) begin
            cnt_q <= cnt_q + `TPW_CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------

    // Levels, enables, mode and clock select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= '0;
        end else if (wr && wb_adr_i == `TPW_OFS_CTRL_ONE) begin
            ctrl_q.lvl1 <= wb_dat_i[`TPW_C1_LVL1];
            ctrl_q.lvl2 <= wb_dat_i[`TPW_C1_LVL2];
            ctrl_q.irq_en <= wb_dat_i[`TPW_C1_IRQ_EN];
        end else if (wr && wb_adr_i == `TPW_OFS_CTRL_TWO) begin
            ctrl_q.sel <= tpw_pkg::tpw_clk_sel_e'(
                wb_dat_i[`TPW_C2_SEL_HI:`TPW_C2_SEL_LO]);
            ctrl_q.pwm <= wb_dat_i[`TPW_C2_PWM];
            ctrl_q.one_pulse_mode <= wb_dat_i[`TPW_C2_OPM];
            ctrl_q.out_en <= wb_dat_i[`TPW_C2_OUT_EN];
        end
    end

    // ------------------------------------------------------------
    // Compare registers
    // ------------------------------------------------------------

    // Software-side copies; high byte write opens an inhibit window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp1_sh_q <= {`TPW_CMP_RESET, `TPW_CMP_RESET};
            cmp2_sh_q <= {`TPW_CMP_RESET, `TPW_CMP_RESET};
            inh1_q <= 1'b0;
            inh2_q <= 1'b0;
        end else if (wr) begin
            case (wb_adr_i)
                `TPW_OFS_CMP1_HI: begin
                    cmp1_sh_q.hi <= wb_dat_i[7:0];
                    inh1_q <= 1'b1;
                end
                `TPW_OFS_CMP1_LO: begin
                    cmp1_sh_q.lo <= wb_dat_i[7:0];
                    inh1_q <= 1'b0;
                end
                `TPW_OFS_CMP2_HI: begin
                    cmp2_sh_q.hi <= wb_dat_i[7:0];
                    inh2_q <= 1'b1;
                end
                `TPW_OFS_CMP2_LO: begin
                    cmp2_sh_q.lo <= wb_dat_i[7:0];
                    inh2_q <= 1'b0;
                end
                default: begin
                    inh1_q <= inh1_q;
                end
            endcase
        end
    end

    // Active copies: follow software outside PWM, and in PWM only
    // move at the period end so a mid-period write cannot glitch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp1_act_q <= {`TPW_CMP_RESET, `TPW_CMP_RESET};
            cmp2_act_q <= {`TPW_CMP_RESET, `TPW_CMP_RESET};
        end else if (ce_i && (!pwm_mode || hit2)) begin
            cmp1_act_q <= cmp1_sh_q;
            cmp2_act_q <= cmp2_sh_q;
        end
    end

    // ------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------

    // Period end wins over the pulse edge when both hit together;
    // equal levels therefore leave the pin constant
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
        end else if (pwm_mode && hit2) begin
            out_q <= ctrl_q.lvl2;
        end else if (hit1) begin
            out_q <= ctrl_q.lvl1;
        end
    end

    // Pin mux: compare output or ordinary port data
    always_comb begin
        pin_select_o = ctrl_q.out_en;
        if (ctrl_q.out_en) begin
            pwm_output_pin_o = out_q;
        end else begin
            pwm_output_pin_o = port_data_i;
        end
    end

    // ------------------------------------------------------------
    // Capture registers
    // ------------------------------------------------------------

    // Capture one latches the count on its pin edge outside PWM
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap1_q <= '0;
        end else if (cap1_edge) begin
            cap1_q <= cnt_q;
        end
    end

    // Capture two keeps working in every mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap2_q <= '0;
        end else if (cap2_edge) begin
            cap2_q <= cnt_q;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------

    // Write one clears; a set in the same cycle wins so no event
    // is lost between software reading and clearing
    logic st_clr;
    assign st_clr = wr && (wb_adr_i == `TPW_OFS_STATUS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_cap1_q <= 1'b0;
            flag_cap2_q <= 1'b0;
            flag_cmp1_q <= 1'b0;
            flag_cmp2_q <= 1'b0;
        end else begin
            flag_cap1_q <= (flag_cap1_q &&
                            !(st_clr && wb_dat_i[`TPW_ST_CAP1])) ||
                           (pwm_mode && hit2) || cap1_edge;
            flag_cap2_q <= (flag_cap2_q &&
                            !(st_clr && wb_dat_i[`TPW_ST_CAP2])) ||
                           cap2_edge;
            flag_cmp1_q <= (flag_cmp1_q &&
                            !(st_clr && wb_dat_i[`TPW_ST_CMP1])) ||
                           (!pwm_mode && hit1);
            flag_cmp2_q <= (flag_cmp2_q &&
                            !(st_clr && wb_dat_i[`TPW_ST_CMP2])) ||
                           (!pwm_mode && hit2);
        end
    end

    // Capture interrupt, gated by enable and the CPU mask
    assign timer_irq_o = flag_cap1_q && ctrl_q.irq_en &&
                         !cpu_irq_mask_i;

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------

    // Single wait-free answer: ack one cycle after the request,
    // dropped the next cycle; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= `TPW_WORD_ZERO;
        end else if (rd) begin
            case (wb_adr_i)
                `TPW_OFS_CTRL_ONE:
                    dat_q <= to_word({ctrl_q.irq_en, 5'h00,
                                      ctrl_q.lvl2, ctrl_q.lvl1});
                `TPW_OFS_CTRL_TWO:
                    dat_q <= to_word({ctrl_q.out_en, 1'b0, ctrl_q.one_pulse_mode,
                                      ctrl_q.pwm, ctrl_q.sel, 2'h0});
                `TPW_OFS_STATUS:
                    dat_q <= to_word({flag_cap1_q, flag_cmp1_q,
                                      flag_cmp2_q, flag_cap2_q, 4'h0});
                `TPW_OFS_CNT_HI: dat_q <= to_word(cnt_q[15:8]);
                `TPW_OFS_CNT_LO: dat_q <= to_word(cnt_q[7:0]);
                `TPW_OFS_CMP1_HI: dat_q <= to_word(cmp1_sh_q.hi);
                `TPW_OFS_CMP1_LO: dat_q <= to_word(cmp1_sh_q.lo);
                `TPW_OFS_CMP2_HI: dat_q <= to_word(cmp2_sh_q.hi);
                `TPW_OFS_CMP2_LO: dat_q <= to_word(cmp2_sh_q.lo);
                `TPW_OFS_CAP1_HI: dat_q <= to_word(cap1_q.hi);
                `TPW_OFS_CAP1_LO: dat_q <= to_word(cap1_q.lo);
                `TPW_OFS_CAP2_HI: dat_q <= to_word(cap2_q.hi);
                `TPW_OFS_CAP2_LO: dat_q <= to_word(cap2_q.lo);
                default: dat_q <= `TPW_WORD_ZERO;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule : tpw_timer

// *** verification/test_tpw_timer.sv ***
// Self-checking bench for the timer PWM block
`include "tpw_regs.svh"
module test_tpw_timer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic [2:0] ext_cnt = 3'h0;
    logic cap1_in = 1'b0;
    logic cap2_in = 1'b0;
    logic irq_mask = 1'b1;
    logic port_data = 1'b0;
    logic pin, pin_sel, irq;
    logic [15:0] hi_len, lo_len, edges;
    int bad_count = 0;
    int num_checks = 0;

    // Clock, and an external count source at one eighth of it
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) ext_cnt <= ext_cnt + 3'h1;

    tpw_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_clk_i(ext_cnt[2]),
        .capture_one_input_i(cap1_in), .capture_two_input_i(cap2_in),
        .cpu_irq_mask_i(irq_mask), .port_data_i(port_data),
        .pwm_output_pin_o(pin), .pin_select_o(pin_sel),
        .timer_irq_o(irq));
    tpw_load i_load (.clk_i(clk_i), .pin_i(pin), .hi_len_o(hi_len),
        .lo_len_o(lo_len), .edges_o(edges));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Classic cycle; only the watchdog ends a wait for a lost ack
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [15:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = {8'h00, rdat[7:0]};
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        wb(1'b0, a, 8'h00, q);
    endtask : rd

    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i);
    endtask : ticks

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [15:0] q;
        rd(`TPW_OFS_CMP1_HI, q);
        check("cmp1 hi reset", q, 16'h00FF);
        rd(8'h3C, q);
        check("unmapped read", q, 16'h0000);
        wr(`TPW_OFS_CAP1_LO, 8'h55);
        rd(`TPW_OFS_CAP1_LO, q);
        check("cap1 lo read only", q, 16'h0000);
        port_data <= 1'b1;
        @(negedge clk_i);
        check("pin shows port", 16'(pin), 16'h0001);
    endtask : t_regs

    // Period 0100h, pulse edge 0080h; opm must not disturb PWM
    task automatic t_pwm(input logic [1:0] sel, input logic one_pulse_mode);
        int div;
        logic [15:0] q;
        div = (sel == 2'b01) ? 2 : (sel == 2'b00) ? 4 : 8;
        wr(`TPW_OFS_CMP2_HI, 8'h01);
        wr(`TPW_OFS_CMP2_LO, 8'h00);
        wr(`TPW_OFS_CMP1_HI, 8'h00);
        wr(`TPW_OFS_CMP1_LO, 8'h80);
        wr(`TPW_OFS_CTRL_ONE, 8'h01);
        wr(`TPW_OFS_CTRL_TWO, {2'b10, one_pulse_mode, 1'b1, sel, 2'b00});
        // Compare flags set by free running before PWM are legal: clear
        wr(`TPW_OFS_STATUS, 8'hF0);
        ticks(3 * 261 * div);
        check("pulse high", hi_len, 16'(128 * div));
        check("pulse low", lo_len, 16'(133 * div));
        rd(`TPW_OFS_STATUS, q);
        check("cap1 flag", q & 16'h0080, 16'h0080);
        check("cmp flags", q & 16'h0060, 16'h0000);
    endtask : t_pwm

    // High byte alone stops compare one; low byte restarts it
    task automatic t_inhibit();
        logic [15:0] e;
        wr(`TPW_OFS_CTRL_TWO, 8'h94);
        wr(`TPW_OFS_CMP1_HI, 8'h00);
        ticks(1044);
        e = edges;
        ticks(522);
        check("inhibited edges", edges, e);
        check("inhibited pin", 16'(pin), 16'h0000);
        wr(`TPW_OFS_CMP1_LO, 8'h40);
        ticks(1566);
        check("new pulse", hi_len, 16'd384);
    endtask : t_inhibit

    task automatic t_levels_irq();
        logic [15:0] e;
        wr(`TPW_OFS_CTRL_ONE, 8'h83);
        ticks(1044);
        e = edges;
        ticks(522);
        check("equal level edges", edges, e);
        check("equal level pin", 16'(pin), 16'h0001);
        irq_mask <= 1'b0;
        @(negedge clk_i);
        check("irq unmasked", 16'(irq), 16'h0001);
        @(posedge clk_i);
        irq_mask <= 1'b1;
        @(negedge clk_i);
        check("irq masked", 16'(irq), 16'h0000);
    endtask : t_levels_irq

    task automatic t_capture();
        logic [15:0] q;
        @(posedge clk_i);
        cap1_in <= 1'b1;
        cap2_in <= 1'b1;
        ticks(4);
        cap1_in <= 1'b0;
        cap2_in <= 1'b0;
        rd(`TPW_OFS_CAP1_LO, q);
        check("cap1 lo", q, 16'h0000);
        rd(`TPW_OFS_CAP1_HI, q);
        check("cap1 hi", q, 16'h0000);
        rd(`TPW_OFS_STATUS, q);
        check("cap2 flag", q & 16'h0010, 16'h0010);
        // Reload every period keeps a mid-period capture in the low page
        rd(`TPW_OFS_CAP2_HI, q);
        check("cap2 hi after reload", q, 16'h0000);
    endtask : t_capture

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        ticks(40000);
        bad_count++;
        end_sim();
    end

    initial begin
        ticks(20);
        rst_i <= 1'b0;
        t_regs();
        t_pwm(2'b01, 1'b0);
        t_pwm(2'b00, 1'b1);
        t_pwm(2'b10, 1'b0);
        t_pwm(2'b11, 1'b0);
        t_inhibit();
        t_levels_irq();
        t_capture();
        end_sim();
    end
endmodule : test_tpw_timer

// *** verification/tpw_load.sv ***
// Load on the PWM pin that measures pulse lengths in clocks
module tpw_load (
    input wire logic clk_i,
    input wire logic pin_i,
    output logic [15:0] hi_len_o,
    output logic [15:0] lo_len_o,
    output logic [15:0] edges_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev_q = 1'b0;
    logic [15:0] run_q = 16'h0001;
    logic [15:0] edges_q = 16'h0000;

    // Length of the last finished high and low phase, and edge count
    always_ff @(posedge clk_i) begin
        prev_q <= pin_i;
        if (pin_i == prev_q) begin
            run_q <= run_q + 16'h0001;
        end else begin
            run_q <= 16'h0001;
            edges_q <= edges_q + 16'h0001;
            if (prev_q) hi_len_o <= run_q;
            else lo_len_o <= run_q;
        end
    end
    assign edges_o = edges_q;
endmodule : tpw_load

// *** verification/tpw_timer_properties.sv ***
// Concurrent checks on the ports of the timer PWM block
module tpw_timer_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cpu_irq_mask_i,
    input wire logic port_data_i,
    input wire logic pwm_output_pin_o,
    input wire logic pin_select_o,
    input wire logic timer_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // A request the slave must take at this edge
    sequence s_req;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
    endsequence
    // Pin moved while routed to the compare output for two cycles
    sequence s_pin_edge;
        pin_select_o [*2] ##0 $changed(pwm_output_pin_o);
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ack_follows_req: assert property (s_req |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && ce_i))
        else $error("ack without request");
    a_read_byte_wide: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read data wider than a byte");
    a_dat_holds: assert property (
        !$past(wb_cyc_i && wb_stb_i) |-> $stable(wb_dat_o))
        else $error("read data moved without request");
    a_port_passes: assert property (
        !pin_select_o |-> pwm_output_pin_o == port_data_i)
        else $error("pin not showing port data");
    a_sel_by_write: assert property (
        $changed(pin_select_o) |-> wb_ack_o && $past(wb_we_i))
        else $error("output route changed without write");
    a_irq_masked: assert property (
        cpu_irq_mask_i |-> !timer_irq_o)
        else $error("interrupt despite mask");
    // Fastest prescale step is two clocks, so no one-cycle glitch
    a_pin_no_glitch: assert property (
        s_pin_edge ##1 pin_select_o |-> $stable(pwm_output_pin_o))
        else $error("pin pulse shorter than a tick");
endmodule : tpw_timer_properties

bind tpw_timer tpw_timer_properties i_props (.clk_i, .rst_i, .ce_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
    .cpu_irq_mask_i, .port_data_i, .pwm_output_pin_o, .pin_select_o,
    .timer_irq_o);
